// File: dso_pkg.sv
// package: codes, register map and status-bus layout of the selector
package dso_pkg;

    // selection codes
    localparam logic [4:0] SEL_LOST_CMD  = 5'h0d;
    localparam logic [4:0] SEL_RUN       = 5'h0e;
    localparam logic [4:0] SEL_STOP      = 5'h0f;
    localparam logic [4:0] SEL_STEADY    = 5'h10;
    localparam logic [4:0] SEL_INV_LINE  = 5'h11;
    localparam logic [4:0] SEL_COMM_LINE = 5'h12;
    localparam logic [4:0] SEL_SEARCH    = 5'h13;
    localparam logic [4:0] SEL_STEP_PLS  = 5'h14;
    localparam logic [4:0] SEL_SEQ_PLS   = 5'h15;
    localparam logic [4:0] SEL_READY     = 5'h16;
    localparam logic [4:0] SEL_TRAVERSE_ACCEL_REACHED   = 5'h17;
    localparam logic [4:0] SEL_TRV_DEC   = 5'h18;
    localparam logic [4:0] SEL_RST       = 5'h00;

    // register byte offsets
    localparam logic [11:0] OFS_SEL    = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_ST = 12'h008;
    localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
    localparam logic [11:0] OFS_IRQ_CL = 12'h010;

    // pulse stretch length for step / sequence pulses, in cycles
    localparam int PULSE_NS  = 100000;
    localparam int CLK_NS    = 25;
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;

    // interrupt status bit positions
    localparam int IRQ_STEP = 0;
    localparam int IRQ_SEQ  = 1;
    localparam int IRQ_RISE = 2;
    localparam int IRQ_W    = 3;

    typedef struct packed {
        logic analog_lost;
        logic comm_lost;
        logic ext_lost;
        logic run_cmd;
        logic volt_out;
        logic dc_brake;
        logic accel;
        logic decel;
        logic inv_line;
        logic exchange_in;
        logic searching;
        logic step_done;
        logic seq_done;
        logic standby;
        logic traverse;
        logic traverse_accel_reached;
        logic traverse_decel_reached;
    } dso_status_s;

endpackage

// File: dso_pulse.sv
// pulse stretcher: widens a one-cycle event into a visible output pulse
`timescale 1ns/1ps
module dso_pulse
    import dso_pkg::*;
#(
    parameter int WIDTH = PULSE_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trig,
    output logic      pulse
);
    localparam int CW = $clog2(WIDTH + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire           busy = (cnt_q != '0);

    assign cnt_d = trig ? CW'(WIDTH) : (busy ? cnt_q - 1'b1 : cnt_q);
    assign pulse = busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // dso_pulse

// File: dso_apb_regs.sv
// apb slave: selection, status, interrupt registers
`timescale 1ns/1ps
module dso_apb_regs
    import dso_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [IRQ_W-1:0] irq_evt,
    input  wire logic             out_level,
    output logic      [4:0]       sel,
    output logic                  irq
);
    logic [4:0]       sel_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ien_q;
    logic             irq_q;
    logic [31:0]      rdat_q;
    logic             rdy_q;
    logic             err_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire acc    = psel & penable;
    wire first  = acc & ~rdy_q;
    wire wr     = acc & rdy_q & pwrite;
    wire hit_se = (paddr == OFS_SEL);
    wire hit_st = (paddr == OFS_STATUS);
    wire hit_is = (paddr == OFS_IRQ_ST);
    wire hit_ie = (paddr == OFS_IRQ_EN);
    wire hit_ic = (paddr == OFS_IRQ_CL);
    wire mapped = hit_se | hit_st | hit_is | hit_ie | hit_ic;
    wire [IRQ_W-1:0] clr = (wr & hit_ic) ? pwdata[IRQ_W-1:0] : '0;
    wire [31:0] rdat = hit_se ? {27'h0, sel_q} :
                       hit_st ? {31'h0, out_level} :
                       hit_is ? {29'h0, ist_q} :
                       hit_ie ? {29'h0, ien_q} : 32'h0;

    assign prdata  = rdat_q;
    assign pready  = rdy_q;
    assign pslverr = err_q;
    assign sel     = sel_q;
    assign irq     = irq_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SEL_RST;
            ist_q <= '0;
            ien_q <= '0;
            irq_q <= 1'b0;
            rdat_q <= 32'h0;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdy_q <= first;
            err_q <= first & ~mapped;
            if (first) rdat_q <= rdat;
            if (wr & hit_se) sel_q <= pwdata[4:0];
            if (wr & hit_ie) ien_q <= pwdata[IRQ_W-1:0];
            ist_q <= (ist_q & ~clr) | irq_evt;
            irq_q <= |(((ist_q & ~clr) | irq_evt) & ien_q);
        end
    end
endmodule // dso_apb_regs

// File: dso_selector.sv
// top: status output selector of the drive
`timescale 1ns/1ps
module dso_selector
    import dso_pkg::*;
#(
    parameter int PULSE_W = PULSE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  dso_status_s      stat,
    output logic             status_out,
    output logic             irq
);
    logic [4:0]       sel;
    logic             step_pls;
    logic             seq_pls;
    logic             out_q;
    logic             out_d;
    logic [IRQ_W-1:0] evt;

    // ------------------------------------------------------------
    // event pulses
    // ------------------------------------------------------------
    dso_pulse #(.WIDTH(PULSE_W)) u_step (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (stat.step_done),
        .pulse   (step_pls)
    );
    dso_pulse #(.WIDTH(PULSE_W)) u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (stat.seq_done),
        .pulse   (seq_pls)
    );

    // ------------------------------------------------------------
    // condition selection
    // ------------------------------------------------------------
    wire c_lost  = stat.ext_lost | stat.analog_lost | stat.comm_lost;
    wire c_run   = stat.run_cmd & stat.volt_out & ~stat.dc_brake;
    wire c_stop  = ~stat.run_cmd & ~stat.volt_out;
    wire c_stdy  = stat.volt_out & ~stat.accel & ~stat.decel;
    wire c_tacc  = stat.traverse & stat.traverse_accel_reached;
    wire c_tdec  = stat.traverse & stat.traverse_decel_reached;

    always_comb begin
        unique case (sel)
            SEL_LOST_CMD:  out_d = c_lost;
            SEL_RUN:       out_d = c_run;
            SEL_STOP:      out_d = c_stop;
            SEL_STEADY:    out_d = c_stdy;
            SEL_INV_LINE:  out_d = stat.inv_line;
            SEL_COMM_LINE: out_d = stat.exchange_in;
            SEL_SEARCH:    out_d = stat.searching;
            SEL_STEP_PLS:  out_d = step_pls;
            SEL_SEQ_PLS:   out_d = seq_pls;
            SEL_READY:     out_d = stat.standby;
            SEL_TRAVERSE_ACCEL_REACHED:   out_d = c_tacc;
            SEL_TRV_DEC:   out_d = c_tdec;
            default:       out_d = 1'b0;
        endcase
    end

    assign evt[IRQ_STEP] = stat.step_done;
    assign evt[IRQ_SEQ]  = stat.seq_done;
    assign evt[IRQ_RISE] = out_d & ~out_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    assign status_out = out_q;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    dso_apb_regs u_regs (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .irq_evt   (evt),
        .out_level (out_q),
        .sel       (sel),
        .irq       (irq)
    );
endmodule // dso_selector

// File: dso_selector_chk.sv
// checker: output of the selector against the stored selection code
`timescale 1ns/1ps
module dso_selector_chk
    import dso_pkg::*;
#(
    parameter int PULSE_W = PULSE_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input dso_status_s      stat,
    input wire logic        status_out
);
    // ------------------------------------------------------------
    // shadow of the selection code, conditions
    // ------------------------------------------------------------
    logic [4:0] sc_q;
    wire wr_sel = psel & penable & pwrite & pready & (paddr == OFS_SEL);
    wire c_lost = stat.analog_lost | stat.comm_lost | stat.ext_lost;
    wire c_run  = stat.run_cmd & stat.volt_out & ~stat.dc_brake;
    wire c_stop = ~stat.run_cmd & ~stat.volt_out;
    wire c_stdy = stat.volt_out & ~stat.accel & ~stat.decel;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sc_q <= SEL_RST;
        else if (wr_sel) sc_q <= pwdata[4:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_on(logic [4:0] c); sc_q == c; endsequence
    sequence s_step; s_on(SEL_STEP_PLS) ##0 stat.step_done; endsequence
    sequence s_seq; s_on(SEL_SEQ_PLS) ##0 stat.seq_done; endsequence
    property p_lost; s_on(SEL_LOST_CMD) |=> status_out == $past(c_lost);
    endproperty
    a_lost: assert property (p_lost) else $error("lost");
    property p_run; s_on(SEL_RUN) |=> status_out == $past(c_run); endproperty
    a_run: assert property (p_run) else $error("run");
    property p_stop; s_on(SEL_STOP) |=> status_out == $past(c_stop);
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_stdy; s_on(SEL_STEADY) |=> status_out == $past(c_stdy);
    endproperty
    a_stdy: assert property (p_stdy) else $error("steady");
    property p_inv; s_on(SEL_INV_LINE) |=> status_out == $past(stat.inv_line);
    endproperty
    a_inv: assert property (p_inv) else $error("inv");
    property p_xch;
        s_on(SEL_COMM_LINE) |=> status_out == $past(stat.exchange_in);
    endproperty
    a_xch: assert property (p_xch) else $error("exch");
    property p_srch;
        s_on(SEL_SEARCH) |=> status_out == $past(stat.searching);
    endproperty
    a_srch: assert property (p_srch) else $error("search");
    property p_step; s_step |=> ##1 status_out [*4]; endproperty
    a_step: assert property (p_step) else $error("step");
    property p_seq; s_seq |=> ##1 status_out [*4]; endproperty
    a_seq: assert property (p_seq) else $error("seq");
    property p_rdy; s_on(SEL_READY) |=> status_out == $past(stat.standby);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_tacc;
        s_on(SEL_TRAVERSE_ACCEL_REACHED) |=> status_out ==
            $past(stat.traverse & stat.traverse_accel_reached);
    endproperty
    a_tacc: assert property (p_tacc) else $error("traverse_accel_reached");
    property p_tdec;
        s_on(SEL_TRV_DEC) |=> status_out ==
            $past(stat.traverse & stat.traverse_decel_reached);
    endproperty
    a_tdec: assert property (p_tdec) else $error("trv dec");
endmodule // dso_selector_chk
bind dso_selector dso_selector_chk #(.PULSE_W(PULSE_W)) dso_selector_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .stat(stat), .status_out(status_out));

// File: dso_reader.sv
// partner: control circuit counting rises of the status output
`timescale 1ns/1ps
module dso_reader (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       level,
    output logic      [7:0] rise_cnt
);
    logic last_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {last_q, rise_cnt} <= 9'h000;
        else {last_q, rise_cnt} <= {level, rise_cnt + {7'h00, level & ~last_q}};
    end
endmodule // dso_reader

// File: dso_selector_test.sv
// testbench: code table, pulses, interrupts, bus errors
`timescale 1ns/1ps
module dso_selector_test
    import dso_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        status_out, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rise_cnt, r0;
    dso_status_s stat;
    int          bad_count = 0, checked = 0, n;
    logic [22:0] tv [20] = '{
        {5'h0d,1'b1,17'h10000}, {5'h0d,1'b1,17'h08000}, {5'h0d,1'b0,17'h03000},
        {5'h0e,1'b1,17'h03000}, {5'h0e,1'b0,17'h03800}, {5'h0f,1'b1,17'h00000},
        {5'h0f,1'b0,17'h01000}, {5'h10,1'b1,17'h01000}, {5'h10,1'b0,17'h01200},
        {5'h11,1'b1,17'h00100}, {5'h11,1'b0,17'h1feff}, {5'h12,1'b1,17'h00080},
        {5'h13,1'b1,17'h00040}, {5'h16,1'b1,17'h00008}, {5'h16,1'b0,17'h1fff7},
        {5'h17,1'b1,17'h00006}, {5'h18,1'b0,17'h00001}, {5'h19,1'b0,17'h1ffff},
        {5'h18,1'b1,17'h00005}, {5'h0d,1'b1,17'h04000}};
    dso_selector #(.PULSE_W(4)) dso_selector_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stat(stat), .status_out(status_out), .irq(irq));
    dso_reader dso_reader_i (.pclk(pclk), .presetn(presetn),
        .level(status_out), .rise_cnt(rise_cnt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic test_done();
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, stat} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_SEL, 32'h0);
        chk(rd, 32'h0);
        chk({status_out, irq}, 2'b00);
        foreach (tv[i]) begin
            apb(1'b1, OFS_SEL, {27'h0, tv[i][22:18]});
            stat <= tv[i][16:0];
            repeat (2) @(posedge pclk);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk(rd, {31'h0, tv[i][17]});
            chk(status_out, tv[i][17]);
        end
        stat <= '0;
        apb(1'b1, OFS_IRQ_CL, 32'h7);
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_SEL, k ? 32'h15 : 32'h14);
            {r0, n} = {rise_cnt, 32'h0};
            stat <= k ? 17'h00010 : 17'h00020;
            @(posedge pclk);
            stat <= '0;
            repeat (10) begin
                @(posedge pclk);
                if (status_out === 1'b1) n++;
            end
            chk(n, 4);
            chk(rise_cnt - r0, 1);
        end
        chk(irq, 1'b1);
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk(rd, 32'h7);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, OFS_IRQ_CL, 32'h7);
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h020, 32'h0e);
        chk(er, 1'b1);
        apb(1'b0, OFS_SEL, 32'h0);
        chk(rd, 32'h15);
        test_done();
    end
endmodule // dso_selector_test
